// File: src/lpms_pkg.sv
`default_nettype none
package lpms_pkg;

  // register byte offsets (word aligned)
  localparam logic [7:0] CTRL_OFF      = 8'h00;  // mode select and standby options
  localparam logic [7:0] WAKE_SEL_OFF  = 8'h04;  // wake source enables
  localparam logic [7:0] SNZ_REQ_OFF   = 8'h08;  // snooze request source enables
  localparam logic [7:0] SNZ_END_OFF   = 8'h0C;  // snooze end source enables
  localparam logic [7:0] STATUS_OFF    = 8'h10;  // current mode, hold, supply
  localparam logic [7:0] IRQ_STAT_OFF  = 8'h14;  // sticky events, clear on read
  localparam logic [7:0] IRQ_MASK_OFF  = 8'h18;  // event mask
  localparam logic [7:0] RTC_SEC_OFF   = 8'h1C;  // rtc seconds count
  localparam logic [7:0] RTC_ALM_OFF   = 8'h20;  // rtc alarm compare
  localparam logic [7:0] RTC_PER_OFF   = 8'h24;  // rtc periodic select
  localparam logic [7:0] TMR_LO_OFF    = 8'h28;  // low timer reload
  localparam logic [7:0] TMR_HI_OFF    = 8'h2C;  // high timer reload
  localparam logic [7:0] TMR_CTRL_OFF  = 8'h30;  // timer enables, cascade

  // control register fields
  localparam int CTRL_STBY_BIT   = 0;  // 1: standby on wfi, 0: sleep
  localparam int CTRL_DEEP_BIT   = 1;  // deep_standby_select
  localparam int CTRL_SNZE_BIT   = 2;  // snooze enable
  localparam int CTRL_KEEP_BIT   = 3;  // deep supply keep option
  localparam int CTRL_HOLDCLR_BIT = 4; // write 1 releases io_hold_state

  // wake source vector positions
  localparam int SRC_W       = 8;
  localparam int SRC_TMR_LO  = 0;
  localparam int SRC_TMR_HI  = 1;
  localparam int SRC_RTC_ALM = 2;
  localparam int SRC_RTC_PER = 3;
  localparam int SRC_EXT0    = 4;  // ordinary / deep-capable external lines
  localparam int SRC_EXT1    = 5;
  localparam int SRC_EXT2    = 6;
  localparam int SRC_EXT3    = 7;

  // interrupt status bits
  localparam int EV_W        = 6;
  localparam int EV_WAKE     = 0;
  localparam int EV_SNZ_IN   = 1;
  localparam int EV_SNZ_OUT  = 2;
  localparam int EV_TMR_LO   = 3;
  localparam int EV_TMR_HI   = 4;
  localparam int EV_RTC_ALM  = 5;

  // reset values and rtc periodic code limit
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam logic [15:0] TMR_LO_RST   = 16'h7FFF;  // sub-clock 32768 ticks
  localparam logic [15:0] TMR_HI_RST   = 16'h0009;  // ten underflows
  localparam logic [1:0]  RTC_PER_MAX  = 2'h3;      // largest periodic code, 2 s

  // timing
  localparam int CLK_HZ          = 10_000_000;
  localparam int LSO_HZ          = 32_768;
  localparam int RTC_TICK_NS     = 1_000_000_000;  // one second
  localparam int WAKE_LAT_NS     = 300;            // resume delay
  localparam int WAKE_LAT_CYC    = (WAKE_LAT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // sequencer modes, gray along normal-standby-snooze path
  typedef enum logic [2:0] {
    LPMS_NORMAL = 3'b000,
    LPMS_SLEEP  = 3'b100,
    LPMS_STBY   = 3'b001,
    LPMS_SNOOZE = 3'b011,
    LPMS_DEEP   = 3'b010,
    LPMS_RESUME = 3'b110
  } lpms_mode_t;

endpackage : lpms_pkg
`default_nettype wire

// File: src/lpms_sync.sv
`timescale 1ns/1ns
`default_nettype none
// two flip-flop synchroniser for a bus of levels
module lpms_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;  // first stage, read only by second

  // two stage capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule : lpms_sync
`default_nettype wire

// File: src/lpms_timer.sv
`timescale 1ns/1ns
`default_nettype none
// reloading down counter with underflow pulse
module lpms_timer #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // control
  input  wire logic         en_i,
  input  wire logic         tick_i,
  input  wire logic [W-1:0] reload_i,
  // status
  output logic      [W-1:0] count_o,
  output logic              uflow_o
);
  // count on tick, reload and pulse at zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= '0;
      uflow_o <= 1'b0;
    end else begin
      uflow_o <= 1'b0;
      if (!en_i) begin
        count_o <= reload_i;  // stopped: preload
      end else if (tick_i) begin
        if (count_o == '0) begin
          count_o <= reload_i;
          uflow_o <= 1'b1;
        end else begin
          count_o <= count_o - W'(1);
        end
      end
    end
  end
endmodule : lpms_timer
`default_nettype wire

// File: src/lpms_top.sv
// Operation
// - standby goes to snooze on request source
// - snooze returns to standby on end source
// - standby wake source wakes from standby, snooze
// - only deep-capable external lines and timer underflows cancel deep
// - supply option keeps or cuts deep domains
// - rtc keeps counting in every mode
// - rtc alarm wakes from snooze or standby
// - rtc periodic interval at most two seconds
// - cascade: high timer counts low underflows
// - low timer underflows once per second at default reload
// - wfi enters mode, configured interrupt cancels
// - deep entry via standby with select set
// - snooze reached only from standby
// - any enabled interrupt cancels sleep
// - deep wake via reset, pins held till release
`timescale 1ns/1ns
`default_nettype none
module lpms_top #(
  parameter int LSO_DIV = 305,  // clk cycles per low-speed osc tick
  parameter int SUB_DIV = 305   // clk cycles per sub-clock tick
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // core side
  input  wire logic        wfi_i,          // wait-for-interrupt executed
  input  wire logic        irq_pending_i,  // any enabled core interrupt
  input  wire logic        irq_serviced_i, // wake interrupt handled
  output logic             core_halt_o,
  output logic             core_resume_o,
  // external pins (asynchronous)
  input  wire logic [3:0]  ext_irq_i,
  input  wire logic [3:0]  deep_standby_wake_irq_i,
  // power outputs
  output logic             deep_reset_o,
  output logic             io_hold_state_o,
  output logic             supply_keep_o,
  output logic             supply_cut_o,
  output logic             irq_o
);
  localparam int SRC_WIDTH = lpms_pkg::SRC_W;  // source vector width
  // synchronised pins
  logic [3:0] ext_s, dsw_s;
  logic       wfi_r;              // wfi edge helper
  logic [31:0] ctrl_r;            // control register
  logic [SRC_WIDTH-1:0] wake_sel_r, snz_req_r, snz_end_r;
  logic [lpms_pkg::EV_W-1:0] ev_stat_r, ev_mask_r, ev_set;
  logic [31:0] rtc_sec_r, rtc_alm_r;
  logic [1:0]  rtc_per_r;
  logic [15:0] tmr_lo_rl_r, tmr_hi_rl_r, tmr_lo_cnt, tmr_hi_cnt;
  logic [2:0]  tmr_ctrl_r;        // lo en, hi en, cascade
  logic        tmr_lo_uf, tmr_hi_uf;
  logic [15:0] lso_div_r, sub_div_r;
  logic        lso_tick, sub_tick;
  logic [15:0] rtc_frac_r;
  logic        rtc_sec_tick, rtc_per_tick, rtc_alm_hit;
  logic [1:0]  per_cnt_r;
  lpms_pkg::lpms_mode_t mode_r, mode_nxt;
  logic [3:0]  lat_r;
  logic [SRC_WIDTH-1:0] src_vec, src_deep;
  logic        bus_req, rd_stat;
  logic [31:0] rd_nxt;

  // pin synchronisers
  lpms_sync #(.W(8)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({ext_irq_i, deep_standby_wake_irq_i}),
    .q_o   ({ext_s, dsw_s})
  );

  // low-speed osc and sub-clock tick dividers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lso_div_r <= 16'h0000;
      sub_div_r <= 16'h0000;
    end else begin
      lso_div_r <= lso_tick ? 16'h0000 : lso_div_r + 16'h0001;
      sub_div_r <= sub_tick ? 16'h0000 : sub_div_r + 16'h0001;
    end
  end
  assign lso_tick = (lso_div_r == 16'(LSO_DIV - 1));
  assign sub_tick = (sub_div_r == 16'(SUB_DIV - 1));

  // rtc seconds, free running on low-speed osc regardless of mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rtc_frac_r <= 16'h0000;
      rtc_sec_r  <= 32'h0000_0000;
      per_cnt_r  <= 2'h0;
    end else begin
      if (bus_req && we_i && adr_i == lpms_pkg::RTC_SEC_OFF) begin
        rtc_sec_r  <= dat_i;
        rtc_frac_r <= 16'h0000;
      end else if (lso_tick) begin
        rtc_frac_r <= rtc_sec_tick ? 16'h0000 : rtc_frac_r + 16'h0001;
        if (rtc_sec_tick) begin
          rtc_sec_r <= rtc_sec_r + 32'h0000_0001;
        end
      end
      if (rtc_sec_tick && lso_tick) begin
        per_cnt_r <= rtc_per_tick ? 2'h0 : per_cnt_r + 2'h1;
      end
    end
  end
  assign rtc_sec_tick = (rtc_frac_r == 16'(lpms_pkg::LSO_HZ - 1));
  // period 1 or 2 s only; longer needs alarm
  assign rtc_per_tick = (per_cnt_r >= {1'b0, rtc_per_r[0]});
  assign rtc_alm_hit  = (rtc_sec_r == rtc_alm_r);

  // low timer on sub-clock, 1 s underflow at default reload
  lpms_timer #(.W(16)) u_tmr_lo (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .en_i     (tmr_ctrl_r[0]),
    .tick_i   (sub_tick),
    .reload_i (tmr_lo_rl_r),
    .count_o  (tmr_lo_cnt),
    .uflow_o  (tmr_lo_uf)
  );

  // high timer counts low underflows in cascade
  lpms_timer #(.W(16)) u_tmr_hi (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .en_i     (tmr_ctrl_r[1]),
    .tick_i   (tmr_ctrl_r[2] ? tmr_lo_uf : sub_tick),
    .reload_i (tmr_hi_rl_r),
    .count_o  (tmr_hi_cnt),
    .uflow_o  (tmr_hi_uf)
  );

  // source vectors; deep accepts only dedicated lines and timer underflows
  assign src_vec  = {ext_s, rtc_per_tick & rtc_sec_tick & lso_tick,
                     rtc_alm_hit & rtc_sec_tick & lso_tick, tmr_hi_uf, tmr_lo_uf};
  assign src_deep = {dsw_s, 1'b0, 1'b0, tmr_hi_uf, tmr_lo_uf};

  // mode sequencer next state
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      lpms_pkg::LPMS_NORMAL: begin
        if (wfi_i && !wfi_r) begin
          if (!ctrl_r[lpms_pkg::CTRL_STBY_BIT]) begin
            mode_nxt = lpms_pkg::LPMS_SLEEP;
          end else begin
            mode_nxt = lpms_pkg::LPMS_STBY;
          end
        end
      end
      lpms_pkg::LPMS_SLEEP: begin
        if (irq_pending_i || |src_vec) begin
          mode_nxt = lpms_pkg::LPMS_RESUME;
        end
      end
      lpms_pkg::LPMS_STBY: begin
        if (ctrl_r[lpms_pkg::CTRL_DEEP_BIT]) begin
          mode_nxt = lpms_pkg::LPMS_DEEP;
        end else if (|(src_vec & wake_sel_r)) begin
          mode_nxt = lpms_pkg::LPMS_RESUME;
        end else if (ctrl_r[lpms_pkg::CTRL_SNZE_BIT] && |(src_vec & snz_req_r)) begin
          mode_nxt = lpms_pkg::LPMS_SNOOZE;
        end
      end
      lpms_pkg::LPMS_SNOOZE: begin
        if (|(src_vec & wake_sel_r)) begin
          mode_nxt = lpms_pkg::LPMS_RESUME;
        end else if (|(src_vec & snz_end_r)) begin
          mode_nxt = lpms_pkg::LPMS_STBY;
        end
      end
      lpms_pkg::LPMS_DEEP: begin
        if (|(src_deep & wake_sel_r)) begin
          mode_nxt = lpms_pkg::LPMS_NORMAL;
        end
      end
      lpms_pkg::LPMS_RESUME: begin
        if (lat_r == 4'h0 && irq_serviced_i) begin
          mode_nxt = lpms_pkg::LPMS_NORMAL;
        end
      end
      default: mode_nxt = lpms_pkg::LPMS_NORMAL;
    endcase
  end

  // mode register and wfi edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= lpms_pkg::LPMS_NORMAL;
      wfi_r  <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      wfi_r  <= wfi_i;
    end
  end

  // resume latency counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lat_r <= 4'h0;
    end else if (mode_nxt == lpms_pkg::LPMS_RESUME && mode_r != lpms_pkg::LPMS_RESUME) begin
      lat_r <= 4'(lpms_pkg::WAKE_LAT_CYC);
    end else if (lat_r != 4'h0) begin
      lat_r <= lat_r - 4'h1;
    end
  end

  // deep wake reset pulse and io hold
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      deep_reset_o    <= 1'b0;
      io_hold_state_o <= 1'b0;
    end else begin
      deep_reset_o <= (mode_r == lpms_pkg::LPMS_DEEP) && (mode_nxt == lpms_pkg::LPMS_NORMAL);
      if (mode_nxt == lpms_pkg::LPMS_DEEP) begin
        io_hold_state_o <= 1'b1;
      end else if (bus_req && we_i && adr_i == lpms_pkg::CTRL_OFF
                   && dat_i[lpms_pkg::CTRL_HOLDCLR_BIT]) begin
        io_hold_state_o <= 1'b0;
      end
    end
  end

  // supply control in deep standby
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      supply_keep_o <= 1'b0;
      supply_cut_o  <= 1'b0;
    end else begin
      supply_keep_o <= mode_nxt == lpms_pkg::LPMS_DEEP && ctrl_r[lpms_pkg::CTRL_KEEP_BIT];
      supply_cut_o  <= mode_nxt == lpms_pkg::LPMS_DEEP && !ctrl_r[lpms_pkg::CTRL_KEEP_BIT];
    end
  end

  // core handshakes
  assign core_halt_o   = (mode_r != lpms_pkg::LPMS_NORMAL) && (mode_r != lpms_pkg::LPMS_RESUME);
  assign core_resume_o = (mode_r == lpms_pkg::LPMS_RESUME) && (lat_r == 4'h0);

  // wishbone request, single cycle ack
  assign bus_req = cyc_i && stb_i && !ack_o;
  assign rd_stat = bus_req && !we_i && adr_i == lpms_pkg::IRQ_STAT_OFF;

  // register writes; clock selection is software's duty in normal mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r      <= lpms_pkg::CTRL_RST;
      wake_sel_r  <= '0;
      snz_req_r   <= '0;
      snz_end_r   <= '0;
      ev_mask_r   <= '0;
      rtc_alm_r   <= 32'hFFFF_FFFF;
      rtc_per_r   <= 2'h0;
      tmr_lo_rl_r <= lpms_pkg::TMR_LO_RST;
      tmr_hi_rl_r <= lpms_pkg::TMR_HI_RST;
      tmr_ctrl_r  <= 3'h0;
    end else if (bus_req && we_i && sel_i[0]) begin
      unique case (adr_i)
        lpms_pkg::CTRL_OFF:     ctrl_r      <= {28'h0, dat_i[3:0]};
        lpms_pkg::WAKE_SEL_OFF: wake_sel_r  <= dat_i[7:0];
        lpms_pkg::SNZ_REQ_OFF:  snz_req_r   <= dat_i[7:0];
        lpms_pkg::SNZ_END_OFF:  snz_end_r   <= dat_i[7:0];
        lpms_pkg::IRQ_MASK_OFF: ev_mask_r   <= dat_i[5:0];
        lpms_pkg::RTC_ALM_OFF:  rtc_alm_r   <= dat_i;
        lpms_pkg::RTC_PER_OFF:  rtc_per_r   <= dat_i[1:0] & lpms_pkg::RTC_PER_MAX;
        lpms_pkg::TMR_LO_OFF:   tmr_lo_rl_r <= dat_i[15:0];
        lpms_pkg::TMR_HI_OFF:   tmr_hi_rl_r <= dat_i[15:0];
        lpms_pkg::TMR_CTRL_OFF: tmr_ctrl_r  <= dat_i[2:0];
        default: ;
      endcase
    end
  end

  // sticky events: set beats clear-on-read
  assign ev_set = {rtc_alm_hit & rtc_sec_tick & lso_tick, tmr_hi_uf, tmr_lo_uf,
                   mode_r == lpms_pkg::LPMS_SNOOZE && mode_nxt == lpms_pkg::LPMS_STBY,
                   mode_r == lpms_pkg::LPMS_STBY && mode_nxt == lpms_pkg::LPMS_SNOOZE,
                   mode_nxt == lpms_pkg::LPMS_RESUME && mode_r != lpms_pkg::LPMS_RESUME};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_stat_r <= '0;
    end else begin
      ev_stat_r <= (rd_stat ? '0 : ev_stat_r) | ev_set;
    end
  end
  assign irq_o = |(ev_stat_r & ev_mask_r);

  // read mux
  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (adr_i)
      lpms_pkg::CTRL_OFF:     rd_nxt = ctrl_r;
      lpms_pkg::WAKE_SEL_OFF: rd_nxt = {24'h0, wake_sel_r};
      lpms_pkg::SNZ_REQ_OFF:  rd_nxt = {24'h0, snz_req_r};
      lpms_pkg::SNZ_END_OFF:  rd_nxt = {24'h0, snz_end_r};
      lpms_pkg::STATUS_OFF:   rd_nxt = {26'h0, supply_keep_o, io_hold_state_o, 1'b0, mode_r};
      lpms_pkg::IRQ_STAT_OFF: rd_nxt = {26'h0, ev_stat_r};
      lpms_pkg::IRQ_MASK_OFF: rd_nxt = {26'h0, ev_mask_r};
      lpms_pkg::RTC_SEC_OFF:  rd_nxt = rtc_sec_r;
      lpms_pkg::RTC_ALM_OFF:  rd_nxt = rtc_alm_r;
      lpms_pkg::RTC_PER_OFF:  rd_nxt = {30'h0, rtc_per_r};
      lpms_pkg::TMR_LO_OFF:   rd_nxt = {tmr_lo_cnt, tmr_lo_rl_r};
      lpms_pkg::TMR_HI_OFF:   rd_nxt = {tmr_hi_cnt, tmr_hi_rl_r};
      lpms_pkg::TMR_CTRL_OFF: rd_nxt = {29'h0, tmr_ctrl_r};
      default:                rd_nxt = 32'h0000_0000;  // unmapped reads zero
    endcase
  end

  // ack and registered read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req;
      if (bus_req && !we_i) begin
        dat_o <= rd_nxt;
      end
    end
  end

endmodule : lpms_top
`default_nettype wire

// File: tb/lpms_chk.sv
`timescale 1ns/1ns
`default_nettype none
// port-level checks of bus handshake and mode sequencing
module lpms_chk (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // bus
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  // core side
  input wire logic        wfi_i,
  input wire logic        irq_serviced_i,
  input wire logic        core_halt_o,
  input wire logic        core_resume_o,
  // power side
  input wire logic        deep_reset_o,
  input wire logic        io_hold_state_o,
  input wire logic        supply_keep_o,
  input wire logic        supply_cut_o
);
  // one clock domain, reset disables all
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // request taken gives ack next cycle
  AST_ACK_NEXT:
    assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  // ack lasts one cycle
  AST_ACK_ONE:
    assert property (ack_o |=> !ack_o) else $error("ack too long");
  // wfi from run mode halts the core
  AST_WFI_HALT:
    assert property ($rose(wfi_i) && !core_halt_o && !core_resume_o |-> ##[1:4] core_halt_o)
      else $error("wfi did not halt");
  // leaving a halt resumes the core or resets from deep
  AST_WAKE_RESUME:
    assert property ($fell(core_halt_o) |-> (deep_reset_o || $past(deep_reset_o))
      or (##[0:4] core_resume_o)) else $error("no resume after wake");
  // resume stands until the handler is done
  AST_RESUME_WAIT:
    assert property (core_resume_o && !irq_serviced_i |=> core_resume_o)
      else $error("resume dropped early");
  // deep wake pulse is single and pins stay held
  AST_DEEP_PULSE:
    assert property (deep_reset_o |=> !deep_reset_o && io_hold_state_o)
      else $error("deep wake pulse or hold wrong");
  // pin hold only released by a control write
  AST_HOLD_REL:
    assert property ($fell(io_hold_state_o) |-> $past(cyc_i && stb_i && we_i
      && adr_i == lpms_pkg::CTRL_OFF && dat_i[lpms_pkg::CTRL_HOLDCLR_BIT]))
      else $error("hold released without write");
  // supply options never both
  AST_SUPPLY_ONE:
    assert property (!(supply_keep_o && supply_cut_o)) else $error("supply both set");
  // supply option applied only while halted
  AST_SUPPLY_HALT:
    assert property ($rose(supply_keep_o || supply_cut_o) |-> core_halt_o)
      else $error("supply option outside deep");

  // main scenarios reached
  COV_DEEP: cover property (deep_reset_o);
  COV_CUT:  cover property (supply_cut_o);
  COV_SVC:  cover property (core_resume_o && irq_serviced_i);
endmodule : lpms_chk
`default_nettype wire

// File: tb/lpms_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// processor core: issues wfi, services the wake interrupt
module lpms_core_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // bench control
  input  wire logic       go_i,
  input  wire logic [3:0] dly_i,
  // sequencer side
  input  wire logic       halt_i,
  input  wire logic       resume_i,
  output logic            wfi_o,
  output logic            serviced_o
);
  logic [3:0] cnt_r; // handler run time

  // wfi only from run mode, held until halted
  always_ff @(posedge clk_i) begin
    if (rst_i || halt_i) begin
      wfi_o <= 1'b0;
    end else if (go_i && !resume_i) begin
      wfi_o <= 1'b1;
    end
  end

  // handler finishes dly_i+1 cycles after resume
  always_ff @(posedge clk_i) begin
    if (rst_i || !resume_i) begin
      cnt_r      <= 4'h0;
      serviced_o <= 1'b0;
    end else if (cnt_r == dly_i) begin
      serviced_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule : lpms_core_model
`default_nettype wire

// File: tb/lpms_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module lpms_top_tb_top;
  // clock, reset, bus
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  // pins and core
  logic        irq_pending_i           = 1'b0;
  logic [3:0]  ext_irq_i               = 4'h0;
  logic [3:0]  deep_standby_wake_irq_i = 4'h0;
  logic        go                      = 1'b0;
  logic [3:0]  dly                     = 4'h0;
  logic        wfi_i, irq_serviced_i, core_halt_o, core_resume_o;
  logic        deep_reset_o, io_hold_state_o, supply_keep_o, supply_cut_o, irq_o;
  // bookkeeping
  int          err_total   = 0;
  int          comparisons = 0;
  logic [31:0] rd;

  lpms_top #(.LSO_DIV(1), .SUB_DIV(1)) u_lpms_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .wfi_i, .irq_pending_i, .irq_serviced_i,
    .core_halt_o, .core_resume_o, .ext_irq_i, .deep_standby_wake_irq_i, .deep_reset_o,
    .io_hold_state_o, .supply_keep_o, .supply_cut_o, .irq_o);
  lpms_core_model u_lpms_core_model (.clk_i, .rst_i, .go_i(go), .dly_i(dly),
    .halt_i(core_halt_o), .resume_i(core_resume_o), .wfi_o(wfi_i), .serviced_o(irq_serviced_i));

  // 100 ns clock
  initial begin
    forever #50 clk_i = ~clk_i;
  end

  // verdict and end of run
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  // compare and count
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // classic single bus cycle, read data into rd
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    chk("ack", 32'(ack_o), 32'h1);
  endtask : wb

  // bounded wait: 0 halted, 1 resuming, 2 running, 3 deep wake
  task automatic til(input int c, input int lim);
    int n;
    n = 0;
    while (n < lim && !((c == 0 && core_halt_o === 1'b1) || (c == 1 && core_resume_o === 1'b1)
        || (c == 2 && core_halt_o === 1'b0 && core_resume_o === 1'b0)
        || (c == 3 && deep_reset_o === 1'b1))) begin
      @(posedge clk_i);
      n++;
    end
  endtask : til

  // core executes wfi and halts
  task automatic wfi_go;
    @(posedge clk_i);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    til(0, 20);
    chk("halt", 32'(core_halt_o), 32'h1);
  endtask : wfi_go

  // reset values and unmapped place
  task automatic t_reset;
    wb(1'b0, lpms_pkg::CTRL_OFF, 32'h0);
    chk("ctrl", rd, lpms_pkg::CTRL_RST);
    wb(1'b0, lpms_pkg::TMR_LO_OFF, 32'h0);
    chk("lo_reload", {16'h0, rd[15:0]}, {16'h0, lpms_pkg::TMR_LO_RST});
    wb(1'b0, lpms_pkg::TMR_HI_OFF, 32'h0);
    chk("hi_reload", {16'h0, rd[15:0]}, {16'h0, lpms_pkg::TMR_HI_RST});
    wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
    wb(1'b0, 8'h3C, 32'h0);
    chk("unmapped", rd, 32'h0);
    wb(1'b1, lpms_pkg::RTC_PER_OFF, 32'hFF);
    wb(1'b0, lpms_pkg::RTC_PER_OFF, 32'h0);
    chk("per_max", rd, {30'h0, lpms_pkg::RTC_PER_MAX});
    chk("hold", 32'(io_hold_state_o), 32'h0);
  endtask : t_reset

  // sleep, cancelled by a pending core interrupt, prompt and slow handler
  task automatic t_sleep;
    wb(1'b1, lpms_pkg::CTRL_OFF, 32'h0);
    for (int i = 0; i < 2; i++) begin
      dly <= (i == 0) ? 4'h0 : 4'h9;
      wfi_go;
      irq_pending_i <= 1'b1;
      til(1, 20);
      chk("sleep_wake", 32'(core_resume_o), 32'h1);
      irq_pending_i <= 1'b0;
      til(2, 40);
      chk("run", 32'(core_halt_o | core_resume_o), 32'h0);
    end
  endtask : t_sleep

  // standby wake, unmasked interrupt, clear on read
  task automatic t_standby;
    wb(1'b1, lpms_pkg::CTRL_OFF, 32'h1);
    wb(1'b1, lpms_pkg::WAKE_SEL_OFF, 32'h10);
    wb(1'b1, lpms_pkg::IRQ_MASK_OFF, 32'h1);
    wb(1'b0, lpms_pkg::IRQ_STAT_OFF, 32'h0);
    wfi_go;
    irq_pending_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk("stby_hold", 32'(core_halt_o), 32'h1);
    irq_pending_i <= 1'b0;
    ext_irq_i[0] <= 1'b1;
    til(1, 20);
    chk("stby_wake", 32'(core_resume_o), 32'h1);
    ext_irq_i[0] <= 1'b0;
    til(2, 40);
    chk("irq_set", 32'(irq_o), 32'h1);
    wb(1'b0, lpms_pkg::IRQ_STAT_OFF, 32'h0);
    chk("wake_ev", 32'(rd[lpms_pkg::EV_WAKE]), 32'h1);
    @(posedge clk_i);
    chk("irq_clr", 32'(irq_o), 32'h0);
  endtask : t_standby

  // pulse one external line for eight cycles
  task automatic pulse(input int k);
    ext_irq_i[k] <= 1'b1;
    repeat (8) @(posedge clk_i);
    ext_irq_i[k] <= 1'b0;
    wb(1'b0, lpms_pkg::IRQ_STAT_OFF, 32'h0);
  endtask : pulse

  // snooze request and end, masked events
  task automatic t_snooze;
    wb(1'b1, lpms_pkg::CTRL_OFF, 32'h5);
    wb(1'b1, lpms_pkg::SNZ_REQ_OFF, 32'h20);
    wb(1'b1, lpms_pkg::SNZ_END_OFF, 32'h40);
    wb(1'b1, lpms_pkg::IRQ_MASK_OFF, 32'h0);
    pulse(1);
    chk("no_snz_run", {30'h0, rd[2:1], core_halt_o}, 32'h0);
    wfi_go;
    pulse(1);
    chk("snz_in", {30'h0, rd[2:1], core_halt_o}, 32'h3);
    pulse(2);
    chk("snz_out", {30'h0, rd[2:1], core_halt_o}, 32'h5);
    pulse(1);
    ext_irq_i[0] <= 1'b1;
    til(1, 20);
    chk("snz_wake", 32'(core_resume_o), 32'h1);
    ext_irq_i[0] <= 1'b0;
    til(2, 40);
    chk("masked", 32'(irq_o), 32'h0);
  endtask : t_snooze

  // cascaded timers wake standby
  task automatic t_timer;
    wb(1'b1, lpms_pkg::TMR_LO_OFF, 32'h3);
    wb(1'b1, lpms_pkg::TMR_HI_OFF, 32'h2);
    wb(1'b1, lpms_pkg::CTRL_OFF, 32'h1);
    wb(1'b1, lpms_pkg::WAKE_SEL_OFF, 32'h2);
    wb(1'b1, lpms_pkg::TMR_CTRL_OFF, 32'h7);
    wfi_go;
    til(1, 60);
    chk("tmr_wake", 32'(core_resume_o), 32'h1);
    til(2, 40);
    wb(1'b0, lpms_pkg::IRQ_STAT_OFF, 32'h0);
    chk("tmr_ev", {30'h0, rd[4:3]}, 32'h3);
    wb(1'b1, lpms_pkg::TMR_CTRL_OFF, 32'h0);
  endtask : t_timer

  // deep entry both supply options, wake lines, pin hold
  task automatic t_deep;
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, lpms_pkg::CTRL_OFF, (k == 0) ? 32'h3 : 32'hB);
      wb(1'b1, lpms_pkg::WAKE_SEL_OFF, 32'h10);
      wfi_go;
      repeat (4) @(posedge clk_i);
      chk("supply", {30'h0, supply_keep_o, supply_cut_o}, (k == 0) ? 32'h1 : 32'h2);
      ext_irq_i[0] <= 1'b1;
      repeat (10) @(posedge clk_i);
      chk("deep_hold", 32'(core_halt_o), 32'h1);
      ext_irq_i[0] <= 1'b0;
      deep_standby_wake_irq_i[0] <= 1'b1;
      til(3, 20);
      chk("deep_wake", 32'(deep_reset_o), 32'h1);
      deep_standby_wake_irq_i[0] <= 1'b0;
      til(2, 20);
      chk("pins_held", {30'h0, io_hold_state_o, core_halt_o}, 32'h2);
      wb(1'b1, lpms_pkg::CTRL_OFF, 32'h10);
      @(posedge clk_i);
      chk("pins_free", 32'(io_hold_state_o), 32'h0);
    end
  endtask : t_deep

  // rtc keeps time in standby and its alarm wakes
  task automatic t_rtc;
    logic [31:0] s;
    wb(1'b0, lpms_pkg::RTC_SEC_OFF, 32'h0);
    s = rd;
    wb(1'b1, lpms_pkg::RTC_ALM_OFF, s);
    wb(1'b1, lpms_pkg::CTRL_OFF, 32'h1);
    wb(1'b1, lpms_pkg::WAKE_SEL_OFF, 32'h4);
    wfi_go;
    til(1, 34000);
    chk("alarm_wake", 32'(core_resume_o), 32'h1);
    til(2, 40);
    wb(1'b0, lpms_pkg::RTC_SEC_OFF, 32'h0);
    chk("rtc_sec", rd, s + 32'h1);
  endtask : t_rtc

  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_sleep;
    t_standby;
    t_snooze;
    t_timer;
    t_deep;
    t_rtc;
    stop_test;
  end

  // watchdog against hangs
  initial begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    stop_test;
  end
endmodule : lpms_top_tb_top

bind lpms_top lpms_chk u_lpms_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i,
  .ack_o, .wfi_i, .irq_serviced_i, .core_halt_o, .core_resume_o, .deep_reset_o,
  .io_hold_state_o, .supply_keep_o, .supply_cut_o);
`default_nettype wire
